// *** rtl/timer16_device.sv ***
`timescale 1ns/1ns
`default_nettype none
module timer16_device
	import timer16_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	timer16_io_if.device    bus,
	input  wire logic       capture_pin,
	input  wire logic       comparator_output,
	input  wire logic [6:0] tick_sources,
	output logic [15:0]     count_value
);
	dev_state_s  s_q;
	dev_state_s  s_d;
	wgm_t        waveform_mode_field;
	logic [2:0]  clock_select_field;
	logic        timer_tick;
	logic [15:0] top;
	logic        at_top;
	logic        at_bottom;
	logic        capture_src;
	logic        capture_hit;

	////////////////////////////////////////////////////////////////////////
	// mode decode and tick selection

	assign waveform_mode_field = {s_q.ctrl_b[`CTRL_B_WGM_HI], s_q.ctrl_a[`CTRL_A_WGM_LO]};
	assign clock_select_field  = s_q.ctrl_b[`CTRL_B_CS];
	// prescaler taps come from outside; code n picks tap n-1
	assign timer_tick = (clock_select_field != `CS_STOP) &&
		tick_sources[3'(clock_select_field - `CS_ONE)];
	assign top       = top_value(waveform_mode_field, s_q.capture);
	assign at_top    = (s_q.count == top);
	assign at_bottom = (s_q.count == `CNT_RESET);
	// switching the source can fake an edge; software clears the flag after
	assign capture_src = s_q.comp_ctrl[`COMP_SEL] ? comparator_output : capture_pin;

	capture_filter u_filter (
		.pclk          (pclk),
		.presetn       (presetn),
		.raw_level     (capture_src),
		.filter_enable (s_q.ctrl_b[`CTRL_B_FILT]),
		.edge_rising   (s_q.ctrl_b[`CTRL_B_EDGE]),
		.run           (!icr_is_top(waveform_mode_field)),
		.capture_hit   (capture_hit)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic ovf_hit;
		logic clr_ovf;
		logic clr_cap;
		ovf_hit = 1'b0;
		clr_ovf = 1'b0;
		clr_cap = 1'b0;
		s_d     = s_q;

		// counting sequence
		if (timer_tick) begin
			if (dual_slope(waveform_mode_field)) begin
				if (s_q.dir == DIR_UP) begin
					if (at_top) begin
						s_d.dir   = DIR_DOWN;
						s_d.count = s_q.count - `CNT_ONE;
					end else begin
						s_d.count = s_q.count + `CNT_ONE;
					end
				end else begin
					if (at_bottom) begin
						s_d.dir   = DIR_UP;
						s_d.count = s_q.count + `CNT_ONE;
						ovf_hit   = 1'b1;
					end else begin
						s_d.count = s_q.count - `CNT_ONE;
					end
				end
			end else begin
				s_d.dir = DIR_UP;
				if (at_top || (s_q.count == `CNT_MAX)) begin
					s_d.count = `CNT_RESET;
				end else begin
					s_d.count = s_q.count + `CNT_ONE;
				end
				// fast pwm overflows at top, normal and ctc at max
				if (fast_pwm(waveform_mode_field)) begin
					ovf_hit = at_top;
				end else begin
					ovf_hit = (s_q.count == `CNT_MAX);
				end
			end
		end

		// capture event; counter value as it stands this cycle
		if (capture_hit) begin
			s_d.capture = s_q.count;
		end

		// cpu reads; side effects on temp happen once per strobe
		if (bus.io_rd) begin
			case (bus.io_addr)
				`IO_CTRL_A: begin
					s_d.rdata = s_q.ctrl_a;
				end
				`IO_CTRL_B: begin
					s_d.rdata = s_q.ctrl_b;
				end
				`IO_CNT_L: begin
					s_d.rdata = s_q.count[7:0];
					s_d.temp  = s_q.count[15:8];
				end
				`IO_CAP_L: begin
					s_d.rdata = s_q.capture[7:0];
					s_d.temp  = s_q.capture[15:8];
				end
				`IO_CNT_H, `IO_CAP_H: begin
					s_d.rdata = s_q.temp;
				end
				`IO_FLAGS: begin
					s_d.rdata            = `REG8_RESET;
					s_d.rdata[`FLAG_OVF] = s_q.ovf_flag;
					s_d.rdata[`FLAG_CAP] = s_q.cap_flag;
				end
				`IO_MASK: begin
					s_d.rdata = s_q.mask;
				end
				`IO_COMP: begin
					s_d.rdata = s_q.comp_ctrl;
				end
				default: begin
					s_d.rdata = `REG8_RESET;
				end
			endcase
		end

		// cpu writes come last so they override counting
		if (bus.io_wr) begin
			case (bus.io_addr)
				`IO_CTRL_A: begin
					s_d.ctrl_a = bus.io_wdata;
				end
				`IO_CTRL_B: begin
					s_d.ctrl_b = bus.io_wdata;
				end
				`IO_CNT_H, `IO_CAP_H: begin
					// temp is shared, so one high write can serve several lows
					s_d.temp = bus.io_wdata;
				end
				`IO_CNT_L: begin
					s_d.count = {s_q.temp, bus.io_wdata};
				end
				`IO_CAP_L: begin
					if (icr_is_top(waveform_mode_field)) begin
						s_d.capture = {s_q.temp, bus.io_wdata};
					end
				end
				`IO_FLAGS: begin
					clr_ovf = bus.io_wdata[`FLAG_OVF];
					clr_cap = bus.io_wdata[`FLAG_CAP];
				end
				`IO_MASK: begin
					s_d.mask = bus.io_wdata;
				end
				`IO_COMP: begin
					s_d.comp_ctrl = bus.io_wdata;
				end
				default: begin
				end
			endcase
		end

		// interrupt taken also clears; a new event wins over any clear
		clr_ovf      = clr_ovf || bus.ack_overflow;
		clr_cap      = clr_cap || bus.ack_capture;
		s_d.ovf_flag = ovf_hit || (s_q.ovf_flag && !clr_ovf);
		s_d.cap_flag = capture_hit || (s_q.cap_flag && !clr_cap);
		s_d.irq_ovf  = s_d.ovf_flag && s_q.mask[`FLAG_OVF];
		s_d.irq_cap  = s_d.cap_flag && s_q.mask[`FLAG_CAP];
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.io_rdata     = s_q.rdata;
	assign bus.irq_capture  = s_q.irq_cap;
	assign bus.irq_overflow = s_q.irq_ovf;
	assign count_value      = s_q.count;
endmodule
`default_nettype wire

// *** rtl/timer16_cfg.svh ***
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH
// device i/o locations
`define IO_CTRL_A      4'h0
`define IO_CTRL_B      4'h1
`define IO_CNT_L       4'h2
`define IO_CNT_H       4'h3
`define IO_CAP_L       4'h4
`define IO_CAP_H       4'h5
`define IO_FLAGS       4'h6
`define IO_MASK        4'h7
`define IO_COMP        4'h8
// device field positions
`define CTRL_A_WGM_LO  1:0
`define CTRL_B_CS      2:0
`define CTRL_B_WGM_HI  4:3
`define CTRL_B_EDGE    6
`define CTRL_B_FILT    7
`define FLAG_OVF       0
`define FLAG_CAP       5
`define COMP_SEL       2
// device reset values and fixed counts
`define REG8_RESET     8'h00
`define CNT_RESET      16'h0000
`define CNT_ONE        16'h0001
`define CNT_MAX        16'hFFFF
`define TOP_8BIT       16'h00FF
`define TOP_9BIT       16'h01FF
`define TOP_10BIT      16'h03FF
`define CS_STOP        3'h0
`define CS_ONE         3'h1
// host apb map
`define APB_CMD        12'h000
`define APB_STATUS     12'h004
`define APB_ACK        12'h008
`define CMD_WDATA      7:0
`define CMD_ADDR       11:8
`define CMD_WRITE      16
`define ST_RDATA       7:0
`define ST_BUSY        8
`define ST_IRQ_CAP     9
`define ST_IRQ_OVF     10
`define ACK_CAP        0
`define ACK_OVF        1
`define WORD_RESET     32'h0000_0000
`endif

// *** rtl/timer16_pkg.sv ***
package timer16_pkg;
`include "timer16_cfg.svh"

typedef logic [3:0] wgm_t;

typedef enum logic [1:0] {
	HOST_IDLE  = 2'b00,
	HOST_ISSUE = 2'b01,
	HOST_TAKE  = 2'b10
} host_state_e;

typedef enum logic {
	DIR_UP   = 1'b0,
	DIR_DOWN = 1'b1
} count_dir_e;

typedef struct packed {
	logic [15:0] count;
	logic [15:0] capture;
	logic [7:0]  temp;
	logic [7:0]  ctrl_a;
	logic [7:0]  ctrl_b;
	logic [7:0]  comp_ctrl;
	logic [7:0]  mask;
	logic        ovf_flag;
	logic        cap_flag;
	count_dir_e  dir;
	logic [7:0]  rdata;
	logic        irq_cap;
	logic        irq_ovf;
} dev_state_s;

typedef struct packed {
	logic [3:0] samples;
	logic       filtered;
	logic       prev;
} filt_state_s;

typedef struct packed {
	host_state_e state;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr_op;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  rdata;
	logic        ack_cap;
	logic        ack_ovf;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
} host_state_s;

function automatic logic icr_is_top(input wgm_t m);
	return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
endfunction

function automatic logic dual_slope(input wgm_t m);
	return ((m >= 4'h1) && (m <= 4'h3)) || ((m >= 4'h8) && (m <= 4'hB));
endfunction

function automatic logic fast_pwm(input wgm_t m);
	return ((m >= 4'h5) && (m <= 4'h7)) || (m == 4'hE) || (m == 4'hF);
endfunction

// modes whose top lives in the absent compare unit run to max
function automatic logic [15:0] top_value(input wgm_t m, input logic [15:0] icr);
	case (m)
		4'h1, 4'h5: return `TOP_8BIT;
		4'h2, 4'h6: return `TOP_9BIT;
		4'h3, 4'h7: return `TOP_10BIT;
		4'h8, 4'hA, 4'hC, 4'hE: return icr;
		default: return `CNT_MAX;
	endcase
endfunction

endpackage

// *** rtl/timer16_io_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface timer16_io_if;
	logic [3:0] io_addr;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       irq_capture;
	logic       irq_overflow;
	logic       ack_capture;
	logic       ack_overflow;

	modport device (
		input  io_addr,
		input  io_wr,
		input  io_rd,
		input  io_wdata,
		input  ack_capture,
		input  ack_overflow,
		output io_rdata,
		output irq_capture,
		output irq_overflow
	);

	modport host (
		output io_addr,
		output io_wr,
		output io_rd,
		output io_wdata,
		output ack_capture,
		output ack_overflow,
		input  io_rdata,
		input  irq_capture,
		input  irq_overflow
	);
endinterface
`default_nettype wire

// *** rtl/capture_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module capture_filter
	import timer16_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic raw_level,
	input  wire logic filter_enable,
	input  wire logic edge_rising,
	input  wire logic run,
	output logic      capture_hit
);
	filt_state_s s_q;
	filt_state_s s_d;
	logic        level;

	// the filtered path lags the plain sample by exactly four cycles
	assign level       = filter_enable ? s_q.filtered : s_q.samples[0];
	assign capture_hit = run && (level != s_q.prev) && (level == edge_rising);

	always_comb begin
		s_d = s_q;
		// frozen while the capture register serves as top
		if (run) begin
			s_d.samples = {s_q.samples[2:0], raw_level};
			if (&s_q.samples) begin
				s_d.filtered = 1'b1;
			end else if (~|s_q.samples) begin
				s_d.filtered = 1'b0;
			end
			s_d.prev = level;
		end
	end

	// filter samples every system clock while run is high, never the timer tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// *** rtl/timer16_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module timer16_host
	import timer16_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	timer16_io_if.host       bus
);
	host_state_s s_q;
	host_state_s s_d;

	always_comb begin
		s_d         = s_q;
		s_d.io_wr   = 1'b0;
		s_d.io_rd   = 1'b0;
		s_d.ack_cap = 1'b0;
		s_d.ack_ovf = 1'b0;

		// setup phase: answer is prepared so pready comes from a flop
		if (psel && !penable) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = !((paddr == `APB_CMD) || (paddr == `APB_STATUS) || (paddr == `APB_ACK));
			s_d.prdata  = `WORD_RESET;
			if (paddr == `APB_STATUS) begin
				s_d.prdata[`ST_RDATA]   = s_q.rdata;
				s_d.prdata[`ST_BUSY]    = (s_q.state != HOST_IDLE);
				s_d.prdata[`ST_IRQ_CAP] = bus.irq_capture;
				s_d.prdata[`ST_IRQ_OVF] = bus.irq_overflow;
			end
		end

		if (psel && penable && s_q.pready) begin
			s_d.pready = 1'b0;
			if (pwrite && (paddr == `APB_CMD) && (s_q.state == HOST_IDLE)) begin
				// one access per command keeps the high-first, low-first order in software
				s_d.addr  = pwdata[`CMD_ADDR];
				s_d.wdata = pwdata[`CMD_WDATA];
				s_d.wr_op = pwdata[`CMD_WRITE];
				s_d.io_wr = pwdata[`CMD_WRITE];
				s_d.io_rd = !pwdata[`CMD_WRITE];
				s_d.state = HOST_ISSUE;
			end
			if (pwrite && (paddr == `APB_ACK)) begin
				s_d.ack_cap = pwdata[`ACK_CAP];
				s_d.ack_ovf = pwdata[`ACK_OVF];
			end
		end

		case (s_q.state)
			HOST_IDLE: begin
			end
			HOST_ISSUE: begin
				s_d.state = s_q.wr_op ? HOST_IDLE : HOST_TAKE;
			end
			HOST_TAKE: begin
				s_d.rdata = bus.io_rdata;
				s_d.state = HOST_IDLE;
			end
			default: begin
				s_d.state = HOST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata           = s_q.prdata;
	assign pready           = s_q.pready;
	assign pslverr          = s_q.pslverr;
	assign bus.io_addr      = s_q.addr;
	assign bus.io_wdata     = s_q.wdata;
	assign bus.io_wr        = s_q.io_wr;
	assign bus.io_rd        = s_q.io_rd;
	assign bus.ack_capture  = s_q.ack_cap;
	assign bus.ack_overflow = s_q.ack_ovf;
endmodule
`default_nettype wire

// *** sim/timer16_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "timer16_cfg.svh"
module timer16_asserts
	import timer16_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [3:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       irq_capture,
	input wire logic       irq_overflow,
	input wire logic       ack_capture,
	input wire logic       ack_overflow
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rw_exclusive: assert property (!(io_wr && io_rd)) else $error("io write and read together");
	a_wr_single: assert property (io_wr |=> !io_wr) else $error("io write longer than one cycle");
	a_rd_single: assert property (io_rd |=> !io_rd) else $error("io read longer than one cycle");
	a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata)) else $error("read data moved without read");
	a_unmapped_zero: assert property (io_rd && io_addr > `IO_COMP |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cmd_held: assert property ($fell(io_wr) |-> $stable(io_addr) && $stable(io_wdata))
		else $error("command fields moved after write");
	a_ack_single: assert property (ack_capture |=> !ack_capture) else $error("ack longer than one cycle");
	// ack may land one edge before the flag register sees it
	a_cap_ack_clear: assert property (ack_capture |-> ##[1:2] !irq_capture) else $error("capture irq stuck");
	a_ovf_ack_clear: assert property (ack_overflow |-> ##[1:2] !irq_overflow) else $error("overflow irq stuck");
endmodule
`default_nettype wire

// *** sim/tb_timer16_counter_input_capture.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "timer16_cfg.svh"
module tb_timer16_counter_input_capture;
	import timer16_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, cmp = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, s;
	logic        pready, pslverr;
	logic [6:0]  tsrc = 0;
	logic [15:0] cnt, c1, c0, d[2];
	logic [7:0]  b;
	int          bad_count = 0, n_compared = 0, cyc = 0;
	always #10 pclk = ~pclk;
	timer16_io_if bus_if();
	timer16_host timer16_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.host));
	timer16_device timer16_device_inst(.pclk(pclk), .presetn(presetn), .bus(bus_if.device), .capture_pin(pin),
		.comparator_output(cmp), .tick_sources(tsrc), .count_value(cnt));
	timer16_asserts timer16_asserts_inst(.pclk(pclk), .presetn(presetn), .io_addr(bus_if.io_addr),
		.io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd), .io_wdata(bus_if.io_wdata), .io_rdata(bus_if.io_rdata),
		.irq_capture(bus_if.irq_capture), .irq_overflow(bus_if.irq_overflow),
		.ack_capture(bus_if.ack_capture), .ack_overflow(bus_if.ack_overflow));
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt, output logic [31:0] r);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= dt; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		// one idle edge so the next call never reassigns psel in this step
		@(posedge pclk);
	endtask
	// one device access, then poll until the host is idle again
	task automatic io(input logic w, input logic [3:0] a, input logic [7:0] dt);
		apb(1'b1, `APB_CMD, {15'h0, w, 4'h0, a, dt}, s);
		s = 32'h0000_0100;
		while (s[8] !== 1'b0) apb(1'b0, `APB_STATUS, 32'h0, s);
		b = s[7:0];
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] dt); io(1'b1, a, dt); endtask
	task automatic rd(input logic [3:0] a); io(1'b0, a, 8'h00); endtask
	task automatic wr16(input logic [3:0] hi, input logic [15:0] v); wr(hi, v[15:8]); wr(hi - 4'h1, v[7:0]); endtask
	task automatic rd16(input logic [3:0] lo); rd(lo); c1[7:0] = b; rd(lo + 4'h1); c1[15:8] = b; endtask
	task automatic tick(input logic [6:0] m); tsrc <= m; @(posedge pclk); tsrc <= 0; @(posedge pclk); endtask
	////////////////////////////////////////////////////////////////
	task automatic t_counter;
		wr(`IO_CTRL_B, 8'h00);
		wr(`IO_CNT_H, 8'hAB);
		wr(`IO_CNT_L, 8'h01);
		chk(cnt, 16'hAB01);
		wr(`IO_CNT_L, 8'h02);
		chk(cnt, 16'hAB02);
		tick(7'h7F);
		chk(cnt, 16'hAB02);
		rd16(`IO_CNT_L);
		chk(c1, 16'hAB02);
		apb(1'b0, 12'h00C, 32'h0, s);
		chk(err, 1'b1);
		rd(4'hF);
		chk(b, 8'h00);
		// free-running tick; the low write lands three ticks before the check
		wr(`IO_CTRL_B, 8'h01);
		tsrc <= 7'h01;
		wr(`IO_CNT_L, 8'h34);
		tsrc <= 7'h00;
		@(posedge pclk);
		chk(cnt, 16'hAB37);
	endtask
	task automatic t_ticks;
		for (int n = 1; n <= 7; n++) begin
			wr(`IO_CTRL_B, {5'h0, 3'(n)});
			wr16(`IO_CNT_H, 16'h0010);
			tick(7'h7F ^ (7'h01 << (n - 1)));
			chk(cnt, 16'h0010);
			tick(7'h01 << (n - 1));
			chk(cnt, 16'h0011);
		end
	endtask
	task automatic t_modes;
		wr(`IO_MASK, 8'h21);
		rd(`IO_MASK);
		chk(b, 8'h21);
		wr(`IO_CTRL_B, 8'h01);
		wr16(`IO_CNT_H, 16'hFFFF);
		tick(7'h01);
		chk(cnt, 16'h0000);
		chk(bus_if.irq_overflow, 1'b1);
		apb(1'b1, `APB_ACK, 32'h2, s);
		repeat (2) @(posedge pclk);
		chk(bus_if.irq_overflow, 1'b0);
		wr(`IO_CTRL_A, 8'h01);
		wr16(`IO_CNT_H, 16'h00FE);
		tick(7'h01);
		chk(cnt, 16'h00FF);
		tick(7'h01);
		chk(cnt, 16'h00FE);
		// still counting down: reach bottom, turn and overflow there
		wr16(`IO_CNT_H, 16'h0001);
		tick(7'h01);
		tick(7'h01);
		chk(cnt, 16'h0001);
		chk(bus_if.irq_overflow, 1'b1);
		apb(1'b1, `APB_ACK, 32'h2, s);
		wr(`IO_CTRL_B, 8'h09);
		wr16(`IO_CNT_H, 16'h00FF);
		tick(7'h01);
		chk(cnt, 16'h0000);
		chk(bus_if.irq_overflow, 1'b1);
		wr(`IO_CTRL_A, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_capture;
		for (int f = 0; f < 2; f++) begin
			pin <= 0;
			wr(`IO_CTRL_B, f ? 8'hC1 : 8'h41);
			tsrc <= 7'h01;
			repeat (10) @(posedge pclk);
			wr(`IO_FLAGS, 8'h21);
			pin <= 1;
			@(posedge pclk);
			c0 = cnt;
			repeat (12) @(posedge pclk);
			tsrc <= 0;
			rd(`IO_FLAGS);
			chk(b[5], 1'b1);
			chk(bus_if.irq_capture, 1'b1);
			chk(s[9], 1'b1);
			rd16(`IO_CAP_L);
			d[f] = c1 - c0;
			apb(1'b1, `APB_ACK, 32'h1, s);
			repeat (2) @(posedge pclk);
			chk(bus_if.irq_capture, 1'b0);
		end
		chk(d[1] - d[0], 16'h0004);
		pin <= 0;
		repeat (3) @(posedge pclk);
		pin <= 1;
		repeat (10) @(posedge pclk);
		rd(`IO_FLAGS);
		chk(b[5], 1'b0);
		pin <= 0;
		repeat (8) @(posedge pclk);
		pin <= 1;
		repeat (10) @(posedge pclk);
		rd(`IO_FLAGS);
		chk(b[5], 1'b1);
	endtask
	task automatic t_source;
		wr(`IO_COMP, 8'h04);
		wr(`IO_FLAGS, 8'h20);
		pin <= 0;
		repeat (8) @(posedge pclk);
		pin <= 1;
		repeat (10) @(posedge pclk);
		rd(`IO_FLAGS);
		chk(b[5], 1'b0);
		cmp <= 1;
		repeat (10) @(posedge pclk);
		rd(`IO_FLAGS);
		chk(b[5], 1'b1);
		wr(`IO_COMP, 8'h00);
		wr(`IO_CTRL_B, 8'h58);
		wr16(`IO_CAP_H, 16'h0155);
		wr(`IO_FLAGS, 8'h20);
		pin <= 0;
		repeat (8) @(posedge pclk);
		pin <= 1;
		repeat (10) @(posedge pclk);
		rd(`IO_FLAGS);
		chk(b[5], 1'b0);
		rd16(`IO_CAP_L);
		chk(c1, 16'h0155);
		wr(`IO_CTRL_B, 8'h40);
		wr16(`IO_CAP_H, 16'h0777);
		rd16(`IO_CAP_L);
		chk(c1, 16'h0155);
	endtask
	// reset in mid-run must clear counter and capture alike
	task automatic t_reset;
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(cnt, 16'h0000);
		rd16(`IO_CAP_L);
		chk(c1, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	// generous ceiling; the whole run needs under a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 50000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_counter();
		t_ticks();
		t_modes();
		t_capture();
		t_source();
		t_reset();
		complete_run;
	end
endmodule
`default_nettype wire
